// >>> hw/rps_pkg.sv
// Contract
// [RQ1] chip_reset_n low holds device in reset, high permits operation.
// [RQ2] rising edge of chip_reset_n starts self-configuration sequence.
// [RQ3] outside party holds reset low until all input clocks are stable.
// [RQ4] during reset drive led selects, mirror reset, converter clock and data low.
// [RQ5] during reset every other output and two-way pin is high impedance.
// [RQ6] mirror_park_n low requests park, high permits leaving park.
// [RQ7] companion drives park level when power loss is imminent.
// [RQ8] strap 0 selects spi command port, 1 selects i2c command port.
// [RQ9] port not chosen becomes diagnostic monitoring port.
// [RQ10] strap pin tristated in reset, sampled about 1.5 us after release.
// [RQ11] after sampling the strap pin may be driven as debug output.
// [RQ12] sampled selection held until next reset assertion.
package rps_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 40000;
   localparam int STRAP_DELAY_PS  = 1500000;          // 1.5 us after release
   localparam int STRAP_DELAY_CYC = STRAP_DELAY_PS / CLK_PERIOD_PS;
   localparam int CNT_W           = 6;
   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic HOST_SEL_SPI = 1'h0;
   localparam logic HOST_SEL_I2C = 1'h1;
   localparam logic PARK_REQ     = 1'h0;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {RPS_RESET, RPS_WAIT_STRAP, RPS_CONFIG, RPS_RUN} rps_state_e;
   typedef struct packed {
      logic cmd_is_i2c;   // command port is i2c
      logic diag_is_spi;  // monitoring port is spi
      logic diag_is_i2c;  // monitoring port is i2c
   } rps_port_s;
endpackage

// >>> hw/rps_sync.sv
`timescale 1ns/100ps
// three-stage pin synchroniser, change accepted when stages two and three agree
module rps_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // pin and filtered level
   input  wire logic pin,
   output logic      level
);
   logic s1, s2, s3;

   // ---------------------------------------------------------------
   // stages
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1 <= 1'h0;
         s2 <= 1'h0;
         s3 <= 1'h0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // accept level when last two stages agree
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         level <= 1'h0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule

// >>> hw/rps_top.sv
`timescale 1ns/100ps
module rps_top #(
   parameter int STRAP_CYC = rps_pkg::STRAP_DELAY_CYC
) (
   // clock and chip reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // park control from companion
   input  wire logic              mirror_park_n,
   // host-port select strap pin
   input  wire logic              host_sel_in,
   output logic                   host_sel_out,
   output logic                   host_sel_oe,
   // debug data for strap pin
   input  wire logic              debug_out,
   input  wire logic              debug_en,
   // reset-low outputs
   input  wire logic [3:0]        led_select_req,
   input  wire logic              mirror_reset_req,
   input  wire logic              conv_clk_req,
   input  wire logic              conv_data_req,
   output logic [3:0]             led_select,
   output logic                   mirror_array_reset_n,
   output logic                   converter_serial_clock,
   output logic                   converter_serial_out,
   // status
   output logic                   in_reset,
   output logic                   config_start,
   output logic                   ready,
   output logic                   pins_enable,
   output logic                   park_request,
   output rps_pkg::rps_port_s     port_sel
);
   rps_pkg::rps_state_e state;
   logic [rps_pkg::CNT_W-1:0] cnt;
   logic park_lvl;
   logic strap_lvl;
   logic strap_taken;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   rps_sync u_park (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (mirror_park_n),
      .level (park_lvl)
   );
   rps_sync u_strap (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (host_sel_in),
      .level (strap_lvl)
   );

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // reset holds state, release starts wait then configuration
   always_ff @(posedge clk) begin
      if (!rst_b) begin                                  // RQ1
         state <= rps_pkg::RPS_RESET;
         cnt   <= '0;
      end else begin
         case (state)
            rps_pkg::RPS_RESET: begin
               state <= rps_pkg::RPS_WAIT_STRAP;          // RQ2
               cnt   <= '0;
            end
            rps_pkg::RPS_WAIT_STRAP: begin
               if (cnt == rps_pkg::CNT_W'(STRAP_CYC - 1)) begin
                  state <= rps_pkg::RPS_CONFIG;
               end
               cnt <= cnt + 1'h1;
            end
            rps_pkg::RPS_CONFIG: begin
               state <= rps_pkg::RPS_RUN;
            end
            rps_pkg::RPS_RUN: begin
               state <= rps_pkg::RPS_RUN;
            end
            default: begin
               state <= rps_pkg::RPS_RESET;
            end
         endcase
      end
   end

   assign in_reset     = !rst_b || state == rps_pkg::RPS_RESET;
   assign config_start = state == rps_pkg::RPS_CONFIG; // RQ2
   assign ready        = state == rps_pkg::RPS_RUN;
   assign pins_enable  = !in_reset;                    // RQ5

   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   // latch selection once, hold until next reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         strap_taken <= 1'h0;
         port_sel    <= '0;
      end else if (state == rps_pkg::RPS_WAIT_STRAP && !strap_taken &&
                   cnt == rps_pkg::CNT_W'(STRAP_CYC - 1)) begin
         strap_taken            <= 1'h1;                  // RQ10
         port_sel.cmd_is_i2c    <= strap_lvl == rps_pkg::HOST_SEL_I2C; // RQ8
         port_sel.diag_is_i2c   <= strap_lvl == rps_pkg::HOST_SEL_SPI; // RQ9
         port_sel.diag_is_spi   <= strap_lvl == rps_pkg::HOST_SEL_I2C; // RQ9
      end
   end                                                    // RQ12

   // strap pin: tristate until sampled, then debug drive
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         host_sel_oe  <= 1'h0;                            // RQ10
         host_sel_out <= 1'h0;
      end else begin
         host_sel_oe  <= strap_taken && debug_en;         // RQ11
         host_sel_out <= strap_taken && debug_out;
      end
   end

   // ---------------------------------------------------------------
   // park and reset-low outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         park_request <= 1'h1;
      end else begin
         park_request <= park_lvl == rps_pkg::PARK_REQ;   // RQ6
      end
   end

   // forced low in reset and until ready, then follow core requests
   always_ff @(posedge clk) begin
      if (!rst_b) begin                                   // RQ4
         led_select             <= 4'h0;
         mirror_array_reset_n   <= 1'h0;
         converter_serial_clock <= 1'h0;
         converter_serial_out   <= 1'h0;
      end else begin
         led_select             <= ready ? led_select_req : 4'h0;
         mirror_array_reset_n   <= ready && mirror_reset_req;
         converter_serial_clock <= ready && conv_clk_req;
         converter_serial_out   <= ready && conv_data_req;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_low_in_reset;
      @(posedge clk) !rst_b |=> led_select == 4'h0 && !mirror_array_reset_n &&
                                !converter_serial_clock && !converter_serial_out;
   endproperty
   a_low_in_reset: assert property (p_low_in_reset) else $error("outputs not low"); // RQ4

   property p_oe_off;
      @(posedge clk) !rst_b |=> !host_sel_oe && !pins_enable;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pin driven in reset"); // RQ5

   property p_start;
      @(posedge clk) disable iff (!rst_b) $rose(state == rps_pkg::RPS_WAIT_STRAP)
         |-> ##[1:60] config_start;
   endproperty
   a_start: assert property (p_start) else $error("config did not start"); // RQ2

   property p_hold;
      @(posedge clk) disable iff (!rst_b) strap_taken |=> $stable(port_sel);
   endproperty
   a_hold: assert property (p_hold) else $error("selection changed"); // RQ12

   property p_exclusive;
      @(posedge clk) disable iff (!rst_b) strap_taken |->
         port_sel.cmd_is_i2c == port_sel.diag_is_spi &&
         port_sel.diag_is_spi != port_sel.diag_is_i2c;
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("ports overlap"); // RQ9

   property p_no_drive_early;
      @(posedge clk) disable iff (!rst_b) !strap_taken |=> !host_sel_oe;
   endproperty
   a_no_drive_early: assert property (p_no_drive_early) else $error("strap driven early"); // RQ10

   property p_park;
      @(posedge clk) disable iff (!rst_b) !park_lvl |=> park_request;
   endproperty
   a_park: assert property (p_park) else $error("park ignored"); // RQ6

   property p_sel;
      @(posedge clk) disable iff (!rst_b) $rose(strap_taken) |->
         port_sel.cmd_is_i2c == $past(strap_lvl);
   endproperty
   a_sel: assert property (p_sel) else $error("wrong port"); // RQ8

   property p_wait_after;
      @(posedge clk) disable iff (!rst_b) $rose(rst_b) |=> state == rps_pkg::RPS_WAIT_STRAP;
   endproperty
   a_wait_after: assert property (p_wait_after) else $error("no start on release"); // RQ2

   property p_config_once;
      @(posedge clk) disable iff (!rst_b) config_start |=> !config_start && ready;
   endproperty
   a_config_once: assert property (p_config_once) else $error("config pulse wrong"); // RQ2

   property p_low_until_ready;
      @(posedge clk) disable iff (!rst_b) !ready |=> led_select == 4'h0 &&
         !mirror_array_reset_n && !converter_serial_clock && !converter_serial_out;
   endproperty
   a_low_until_ready: assert property (p_low_until_ready) else $error("outputs early"); // RQ4

   property p_debug_drive;
      @(posedge clk) disable iff (!rst_b) strap_taken && debug_en |=>
         host_sel_oe && host_sel_out == $past(debug_out);
   endproperty
   a_debug_drive: assert property (p_debug_drive) else $error("debug drive lost"); // RQ11

   property p_unpark;
      @(posedge clk) disable iff (!rst_b) park_lvl |=> !park_request;
   endproperty
   a_unpark: assert property (p_unpark) else $error("park stuck"); // RQ6
endmodule

// >>> test/rps_companion.sv
`timescale 1ns/100ps
// -----------------------------------------------------------
// companion chip and board straps beside the controller
// -----------------------------------------------------------
module rps_companion (
   // clock
   input  wire logic clk,
   // board conditions
   input  wire logic power_fail,
   input  wire logic strap_hi,
   // strap pin drive from the controller
   input  wire logic host_sel_out,
   input  wire logic host_sel_oe,
   // pins toward the controller
   output logic      mirror_park_n,
   output logic      host_sel_in
);
   // park level as soon as power loss is seen
   always_ff @(posedge clk) begin
      mirror_park_n <= !power_fail;
   end
   // weak pulldown unless a pullup strap is fitted or the pin is driven
   assign host_sel_in = host_sel_oe ? host_sel_out : strap_hi;
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
   // -----------------------------------------------------------
   // signals
   // -----------------------------------------------------------
   logic               clk, rst_b, power_fail, strap_hi, debug_out, debug_en;
   logic               mirror_park_n, host_sel_in, host_sel_out, host_sel_oe;
   logic [3:0]         led_req, led_select;
   logic               mr_req, cc_req, cd_req, mr_n, cclk, cdat;
   logic               in_reset, config_start, ready, pins_enable, park_request;
   rps_pkg::rps_port_s port_sel;
   int                 num_errors, n_tests;

   rps_companion u_comp (.clk(clk), .power_fail(power_fail), .strap_hi(strap_hi),
      .host_sel_out(host_sel_out), .host_sel_oe(host_sel_oe),
      .mirror_park_n(mirror_park_n), .host_sel_in(host_sel_in));

   rps_top #(.STRAP_CYC(4)) u_dut (.clk(clk), .rst_b(rst_b), .mirror_park_n(mirror_park_n),
      .host_sel_in(host_sel_in), .host_sel_out(host_sel_out), .host_sel_oe(host_sel_oe),
      .debug_out(debug_out), .debug_en(debug_en), .led_select_req(led_req),
      .mirror_reset_req(mr_req), .conv_clk_req(cc_req), .conv_data_req(cd_req),
      .led_select(led_select), .mirror_array_reset_n(mr_n), .converter_serial_clock(cclk),
      .converter_serial_out(cdat), .in_reset(in_reset), .config_start(config_start),
      .ready(ready), .pins_enable(pins_enable), .park_request(park_request),
      .port_sel(port_sel));

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   // clock generation, 40 ns period
   initial begin
      clk = 1'h0;
      forever #20 clk = !clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   // reset with strap level s, then boot until ready
   task automatic t_boot(input logic s);
      int i;
      @(posedge clk);
      rst_b    <= 1'h0;
      strap_hi <= s;
      repeat (2) @(posedge clk);
      #1;
      chk({1'h0, led_select, mr_n, cclk, cdat}, 8'h00);
      chk({5'h00, host_sel_oe, pins_enable, in_reset}, 8'h01);
      chk({5'h00, port_sel}, 8'h00);
      @(posedge clk);
      rst_b <= 1'h1;
      for (i = 0; i < 60 && config_start !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
      chk({7'h00, config_start}, 8'h01);
      chk({3'h0, led_select, mr_n}, 8'h00);
      @(posedge clk);
      #1;
      chk({5'h00, port_sel}, s ? 8'h06 : 8'h01);
      chk({6'h00, ready, pins_enable}, 8'h03);
      @(posedge clk);
      #1;
      chk({1'h0, led_select, mr_n, cclk, cdat}, {1'h0, led_req, mr_req, cc_req, cd_req});
      $display("boot test done, strap %0h", s);
   endtask

   // strap pin moved and reused after sampling
   task automatic t_hold(input logic s);
      @(posedge clk);
      strap_hi  <= !s;
      debug_en  <= 1'h1;
      debug_out <= 1'h1;
      repeat (8) @(posedge clk);
      #1;
      chk({5'h00, port_sel}, s ? 8'h06 : 8'h01);
      chk({6'h00, host_sel_oe, host_sel_out}, 8'h03);
      @(posedge clk);
      debug_out <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk({6'h00, host_sel_oe, host_sel_out}, 8'h02);
      @(posedge clk);
      debug_en <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk({6'h00, host_sel_oe, host_sel_out}, 8'h00);
      $display("strap hold test done");
   endtask

   // park request from the companion
   task automatic t_park();
      chk({7'h00, park_request}, 8'h00);
      @(posedge clk);
      power_fail <= 1'h1;
      repeat (8) @(posedge clk);
      #1;
      chk({7'h00, park_request}, 8'h01);
      @(posedge clk);
      power_fail <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
      chk({7'h00, park_request}, 8'h00);
      $display("park test done");
   endtask

   // -----------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------
   initial begin
      rst_b      = 1'h0;
      power_fail = 1'h0;
      strap_hi   = 1'h0;
      debug_out  = 1'h1;
      debug_en   = 1'h0;
      led_req    = 4'hA;
      mr_req     = 1'h1;
      cc_req     = 1'h0;
      cd_req     = 1'h1;
      num_errors = 0;
      n_tests    = 0;
      t_boot(1'h0);
      t_hold(1'h0);
      t_park();
      t_boot(1'h1);
      t_hold(1'h1);
      conclude();
   end

   // cut a hang short
   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      conclude();
   end
endmodule
